// *** design/flsl_lockout.sv ***
`timescale 1ns/1ps
// Operation
// RULE_01: Security word 0x0002 means device secured.
// RULE_02: Secured state reloaded from flash each start.
// RULE_03: Secured disables debug emulation, execution unchanged.
// RULE_04: Chip TAP always active, boundary and ID. This TAP has an ID register but no boundary-scan register.
// RULE_05: Debug flash block active right at reset.
// RULE_06: Recovery mass-erases, clears protection; unsecured after reset.
// RULE_07: Host loads lockout recovery instruction first.
// RULE_08: Host shifts seven-bit clock divider value.
// RULE_09: Erase runs while TAP held in idle.
// RULE_10: Host resets TAP and device after recovery.
// RULE_11: Security word zero unsecures after reset.
// RULE_12: Programming only clears bits; ones need erase.
// RULE_13: Matching four-word key unlocks immediately.
// RULE_14: Key given as four consecutive flash accesses.
// RULE_15: Back-door unlock lasts until next reset.
// RULE_16: Any mismatching key word keeps device secured.
module flsl_lockout (
  input  wire logic                          clk_in,             // 125 MHz clock
  input  wire logic                          rst_in,             // Device and power-on reset
  input  wire flsl_pkg::flsl_jtag_t          jtag_in,            // TAP pins, asynchronous
  output logic                               tdo_out,            // TAP data out
  output logic                               tdo_oe_out,         // TAP data out enable
  output logic [flsl_pkg::ADDR_W-1:0]        flash_rd_addr_out,  // Boot read address
  input  wire logic [flsl_pkg::DATA_W-1:0]   flash_rd_data_in,   // Read data, one cycle late
  input  wire logic                          key_wr_in,          // Key word access strobe
  input  wire logic [flsl_pkg::DATA_W-1:0]   key_data_in,        // Presented key word
  input  wire logic                          flash_acc_in,       // Any other flash access
  input  wire flsl_pkg::flsl_prog_t          prog_in,            // Program request
  output logic                               prog_req_out,       // Program request to array
  output logic [flsl_pkg::DATA_W-1:0]        prog_data_out,      // Word to program
  input  wire logic                          erase_done_in,      // Mass erase finished
  output logic                               erase_req_out,      // Mass erase request
  output logic [flsl_pkg::DIV_W-1:0]         clk_div_out,        // Erase clock divider
  output logic                               prot_clear_out,     // Clear protection register
  output logic                               secured_out,        // Device currently secured
  output logic                               dbg_en_out,         // Debug emulation allowed
  output logic                               boot_done_out       // Security word loaded
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic flsl_pkg::flsl_tap_t tap_next(input flsl_pkg::flsl_tap_t s, input logic m);
    unique case (s)
      flsl_pkg::TAP_RESET:     tap_next = m ? flsl_pkg::TAP_RESET    : flsl_pkg::TAP_IDLE;
      flsl_pkg::TAP_IDLE:      tap_next = m ? flsl_pkg::TAP_SEL_DR   : flsl_pkg::TAP_IDLE;
      flsl_pkg::TAP_SEL_DR:    tap_next = m ? flsl_pkg::TAP_SEL_IR   : flsl_pkg::TAP_CAP_DR;
      flsl_pkg::TAP_CAP_DR:    tap_next = m ? flsl_pkg::TAP_EXIT1_DR : flsl_pkg::TAP_SHIFT_DR;
      flsl_pkg::TAP_SHIFT_DR:  tap_next = m ? flsl_pkg::TAP_EXIT1_DR : flsl_pkg::TAP_SHIFT_DR;
      flsl_pkg::TAP_EXIT1_DR:  tap_next = m ? flsl_pkg::TAP_UPDATE_DR : flsl_pkg::TAP_PAUSE_DR;
      flsl_pkg::TAP_PAUSE_DR:  tap_next = m ? flsl_pkg::TAP_EXIT2_DR : flsl_pkg::TAP_PAUSE_DR;
      flsl_pkg::TAP_EXIT2_DR:  tap_next = m ? flsl_pkg::TAP_UPDATE_DR : flsl_pkg::TAP_SHIFT_DR;
      flsl_pkg::TAP_UPDATE_DR: tap_next = m ? flsl_pkg::TAP_SEL_DR   : flsl_pkg::TAP_IDLE;
      flsl_pkg::TAP_SEL_IR:    tap_next = m ? flsl_pkg::TAP_RESET    : flsl_pkg::TAP_CAP_IR;
      flsl_pkg::TAP_CAP_IR:    tap_next = m ? flsl_pkg::TAP_EXIT1_IR : flsl_pkg::TAP_SHIFT_IR;
      flsl_pkg::TAP_SHIFT_IR:  tap_next = m ? flsl_pkg::TAP_EXIT1_IR : flsl_pkg::TAP_SHIFT_IR;
      flsl_pkg::TAP_EXIT1_IR:  tap_next = m ? flsl_pkg::TAP_UPDATE_IR : flsl_pkg::TAP_PAUSE_IR;
      flsl_pkg::TAP_PAUSE_IR:  tap_next = m ? flsl_pkg::TAP_EXIT2_IR : flsl_pkg::TAP_PAUSE_IR;
      flsl_pkg::TAP_EXIT2_IR:  tap_next = m ? flsl_pkg::TAP_UPDATE_IR : flsl_pkg::TAP_SHIFT_IR;
      flsl_pkg::TAP_UPDATE_IR: tap_next = m ? flsl_pkg::TAP_SEL_DR   : flsl_pkg::TAP_IDLE;
    endcase
  endfunction

  function automatic logic [flsl_pkg::ADDR_W-1:0] boot_addr(input logic [2:0] idx);
    boot_addr = (idx == 3'h0) ? flsl_pkg::SEC_ADDR
                              : flsl_pkg::KEY_ADDR0 + flsl_pkg::ADDR_W'(idx - 3'h1);
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] jtag_s1_q;
  logic [2:0] jtag_s2_q;
  logic       tck_d1_q;
  logic       tck_rise;
  logic       tck_fall;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      jtag_s1_q <= 3'h0;
      jtag_s2_q <= 3'h0;
      tck_d1_q  <= 1'b0;
    end else begin
      jtag_s1_q <= {jtag_in.tck, jtag_in.tms, jtag_in.tdi};
      jtag_s2_q <= jtag_s1_q;
      tck_d1_q  <= jtag_s2_q[2];
    end
  end

  assign tck_rise = jtag_s2_q[2] & ~tck_d1_q;
  assign tck_fall = ~jtag_s2_q[2] & tck_d1_q;

  // ------------------------------------------------------------
  // Boot load of security word and key
  // ------------------------------------------------------------
  // Secured until proven otherwise, so debug is shut before any code runs
  logic [2:0]                  rd_idx_q;
  logic [flsl_pkg::ADDR_W-1:0] rd_addr_q;
  logic                        boot_done_q;
  logic                        secured_q;
  logic [flsl_pkg::DATA_W-1:0] key_q [flsl_pkg::KEY_WORDS];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_idx_q    <= 3'h0;
      rd_addr_q   <= flsl_pkg::SEC_ADDR;
      boot_done_q <= 1'b0;
      secured_q   <= 1'b1;                                               // RULE_05
    end else if (!boot_done_q) begin
      rd_idx_q  <= rd_idx_q + 3'h1;
      rd_addr_q <= boot_addr(rd_idx_q + 3'h1);
      if (rd_idx_q == flsl_pkg::BOOT_SEC_IDX) begin
        secured_q <= (flash_rd_data_in == flsl_pkg::SEC_WORD_SECURED);   // RULE_01 RULE_02 RULE_11
      end
      if (rd_idx_q == flsl_pkg::BOOT_LAST_IDX) begin
        boot_done_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < flsl_pkg::KEY_WORDS; i++) begin
        key_q[i] <= 16'h0000;
      end
    end else if (!boot_done_q && rd_idx_q > flsl_pkg::BOOT_SEC_IDX) begin
      key_q[2'(rd_idx_q - 3'h2)] <= flash_rd_data_in;
    end
  end

  // ------------------------------------------------------------
  // Back-door key compare
  // ------------------------------------------------------------
  // Any other flash access restarts the sequence, so the key must arrive unbroken
  logic [1:0] key_pos_q;
  logic       key_ok_q;
  logic       unlock_q;
  logic       key_match;

  assign key_match = (key_data_in == key_q[key_pos_q]);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      key_pos_q <= 2'h0;
      key_ok_q  <= 1'b0;
      unlock_q  <= 1'b0;                                                 // RULE_15
    end else if (boot_done_q) begin
      if (key_wr_in) begin
        key_pos_q <= key_pos_q + 2'h1;
        key_ok_q  <= ((key_pos_q == 2'h0) | key_ok_q) & key_match;      // RULE_16
        if (key_pos_q == 2'h3 && key_ok_q && key_match) begin
          unlock_q <= 1'b1;                                              // RULE_13 RULE_14
        end
      end else if (flash_acc_in) begin
        key_pos_q <= 2'h0;                                               // RULE_14
        key_ok_q  <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Debug gating and programming
  // ------------------------------------------------------------
  logic                        dbg_en_q;
  logic                        sec_out_q;
  logic                        prog_req_q;
  logic [flsl_pkg::DATA_W-1:0] prog_data_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dbg_en_q  <= 1'b0;
      sec_out_q <= 1'b1;                                                 // RULE_05
    end else begin
      dbg_en_q  <= boot_done_q & (~secured_q | unlock_q);                // RULE_03 RULE_05
      sec_out_q <= secured_q & ~unlock_q;                                // RULE_13 RULE_15
    end
  end

  // Programming can only pull bits low; the old word masks the new one
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prog_req_q  <= 1'b0;
      prog_data_q <= 16'h0000;
    end else begin
      prog_req_q  <= prog_in.req;
      prog_data_q <= prog_in.old_word & prog_in.new_word;                // RULE_12
    end
  end

  // ------------------------------------------------------------
  // TAP controller, sampled on the fast clock
  // ------------------------------------------------------------
  flsl_pkg::flsl_tap_t     tap_q;
  logic [flsl_pkg::IR_W-1:0] ir_q;
  logic [flsl_pkg::IR_W-1:0] ir_sh_q;
  logic [flsl_pkg::DR_W-1:0] dr_sh_q;
  logic [flsl_pkg::DIV_W-1:0] div_q;
  logic                    dr_upd_q;
  logic                    tdo_q;
  logic                    tdo_oe_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tap_q <= flsl_pkg::TAP_RESET;
    end else if (tck_rise) begin
      tap_q <= tap_next(tap_q, jtag_s2_q[1]);                           // RULE_04
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ir_q    <= flsl_pkg::IR_IDCODE;
      ir_sh_q <= 4'h0;
    end else if (tck_rise) begin
      unique case (tap_q)
        flsl_pkg::TAP_RESET:     ir_q    <= flsl_pkg::IR_IDCODE;
        flsl_pkg::TAP_CAP_IR:    ir_sh_q <= flsl_pkg::IR_CAPTURE;
        flsl_pkg::TAP_SHIFT_IR:  ir_sh_q <= {jtag_s2_q[0], ir_sh_q[3:1]};
        flsl_pkg::TAP_UPDATE_IR: ir_q    <= ir_sh_q;                     // RULE_07
        default: ;
      endcase
    end
  end

  // Debug instruction reads as bypass; emulation access rides on dbg_en_out
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dr_sh_q  <= 32'h0000_0000;
      div_q    <= 7'h00;
      dr_upd_q <= 1'b0;
    end else if (tck_rise) begin
      if (tap_q == flsl_pkg::TAP_RESET || tap_q == flsl_pkg::TAP_UPDATE_IR) begin
        dr_upd_q <= 1'b0;
      end
      if (tap_q == flsl_pkg::TAP_CAP_DR) begin
        dr_sh_q <= (ir_q == flsl_pkg::IR_IDCODE) ? flsl_pkg::IDCODE_VAL : 32'h0000_0000; // RULE_04
      end else if (tap_q == flsl_pkg::TAP_SHIFT_DR) begin
        if (ir_q == flsl_pkg::IR_IDCODE) begin
          dr_sh_q <= {jtag_s2_q[0], dr_sh_q[31:1]};
        end else if (ir_q == flsl_pkg::IR_LOCKOUT) begin
          dr_sh_q <= {25'h0000000, jtag_s2_q[0], dr_sh_q[6:1]};         // RULE_08
        end else begin
          dr_sh_q <= {31'h00000000, jtag_s2_q[0]};
        end
      end else if (tap_q == flsl_pkg::TAP_UPDATE_DR && ir_q == flsl_pkg::IR_LOCKOUT) begin
        div_q    <= dr_sh_q[6:0];                                        // RULE_08
        dr_upd_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_q    <= (tap_q == flsl_pkg::TAP_SHIFT_IR) ? ir_sh_q[0] : dr_sh_q[0];
      tdo_oe_q <= (tap_q == flsl_pkg::TAP_SHIFT_IR) | (tap_q == flsl_pkg::TAP_SHIFT_DR);
    end
  end

  // ------------------------------------------------------------
  // Lockout recovery erase
  // ------------------------------------------------------------
  // Security is not dropped here: only the reload after reset clears it
  logic erase_req_q;
  logic erase_fin_q;
  logic prot_clr_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      erase_req_q <= 1'b0;
      erase_fin_q <= 1'b0;
      prot_clr_q  <= 1'b0;
    end else begin
      erase_req_q <= (tap_q == flsl_pkg::TAP_IDLE) & (ir_q == flsl_pkg::IR_LOCKOUT) &
                     dr_upd_q & ~erase_fin_q & ~(erase_req_q & erase_done_in); // RULE_09
      prot_clr_q  <= erase_req_q & erase_done_in;                        // RULE_06
      if (erase_req_q && erase_done_in) begin
        erase_fin_q <= 1'b1;                                             // RULE_06
      end
    end
  end

  assign tdo_out           = tdo_q;
  assign tdo_oe_out        = tdo_oe_q;
  assign flash_rd_addr_out = rd_addr_q;
  assign prog_req_out      = prog_req_q;
  assign prog_data_out     = prog_data_q;
  assign erase_req_out     = erase_req_q;
  assign clk_div_out       = div_q;
  assign prot_clear_out    = prot_clr_q;
  assign secured_out       = sec_out_q;
  assign dbg_en_out        = dbg_en_q;
  assign boot_done_out     = boot_done_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sec_load_a: assert property (rd_idx_q == flsl_pkg::BOOT_SEC_IDX && !boot_done_q |=>
    secured_q == ($past(flash_rd_data_in) == flsl_pkg::SEC_WORD_SECURED)) // RULE_01
    else $error("security word not decoded");
  open_word_a: assert property (rd_idx_q == flsl_pkg::BOOT_SEC_IDX && !boot_done_q &&
    flash_rd_data_in == flsl_pkg::SEC_WORD_OPEN |=> !secured_q)          // RULE_11
    else $error("zero word left device secured");
  early_block_a: assert property (!boot_done_q |-> !dbg_en_out)          // RULE_05
    else $error("debug open before boot load");
  dbg_gate_a: assert property (secured_q && !unlock_q |=> !dbg_en_out)   // RULE_03
    else $error("debug open while secured");
  tap_alive_a: assert property (tck_rise && tap_q == flsl_pkg::TAP_RESET && !jtag_s2_q[1]
    |=> tap_q == flsl_pkg::TAP_IDLE)                                     // RULE_04
    else $error("tap did not leave reset");
  div_load_a: assert property (tck_rise && tap_q == flsl_pkg::TAP_UPDATE_DR &&
    ir_q == flsl_pkg::IR_LOCKOUT |=> clk_div_out == $past(dr_sh_q[6:0]) && dr_upd_q) // RULE_08
    else $error("divider not updated");
  erase_idle_a: assert property (erase_req_out |-> tap_q == flsl_pkg::TAP_IDLE ##0
    ir_q == flsl_pkg::IR_LOCKOUT)                                        // RULE_09
    else $error("erase outside idle");
  erase_end_a: assert property (erase_req_out && erase_done_in |=>
    prot_clear_out && !erase_req_out && secured_q == $past(secured_q))   // RULE_06
    else $error("erase completion wrong");
  prog_mask_a: assert property (prog_in.req |=>
    prog_req_out && (prog_data_out & ~$past(prog_in.old_word)) == 16'h0000) // RULE_12
    else $error("program set a bit");
  unlock_cause_a: assert property ($rose(unlock_q) |->
    $past(key_wr_in) && $past(key_pos_q) == 2'h3)                        // RULE_13
    else $error("unlock without full key");
  key_bad_a: assert property (key_wr_in && boot_done_q && !unlock_q && !key_match
    |=> !unlock_q)                                                       // RULE_16
    else $error("bad key unlocked");

  erase_cov_c:  cover property (erase_req_out ##[1:64] prot_clear_out);
  unlock_cov_c: cover property (secured_q && !unlock_q ##1 unlock_q);
  dbg_cov_c:    cover property (boot_done_q && dbg_en_out);

endmodule

// *** shared/flsl_pkg.sv ***
package flsl_pkg;

  // ------------------------------------------------------------
  // Flash map and security encodings
  // ------------------------------------------------------------
  localparam int          ADDR_W           = 16;
  localparam int          DATA_W           = 16;
  localparam logic [15:0] SEC_ADDR         = 16'h1ff7;
  localparam logic [15:0] SEC_WORD_SECURED = 16'h0002;
  localparam logic [15:0] SEC_WORD_OPEN    = 16'h0000;
  localparam logic [15:0] KEY_ADDR0        = 16'h1ffc;
  localparam int          KEY_WORDS        = 4;
  localparam logic [2:0]  BOOT_SEC_IDX     = 3'h1;
  localparam logic [2:0]  BOOT_LAST_IDX    = 3'h5;

  // ------------------------------------------------------------
  // Chip-level test access port
  // ------------------------------------------------------------
  localparam int          IR_W        = 4;
  localparam logic [3:0]  IR_CAPTURE  = 4'h1;
  localparam logic [3:0]  IR_IDCODE   = 4'h2;
  localparam logic [3:0]  IR_DEBUG    = 4'h7;
  localparam logic [3:0]  IR_LOCKOUT  = 4'h8;
  localparam logic [3:0]  IR_BYPASS   = 4'hf;
  localparam int          DIV_W       = 7;
  localparam int          DR_W        = 32;
  // Identification value is arbitrary; bit 0 must stay set
  localparam logic [31:0] IDCODE_VAL  = 32'h0000_1001;

  typedef enum logic [3:0] {
    TAP_EXIT2_DR  = 4'h0, TAP_EXIT1_DR  = 4'h1, TAP_SHIFT_DR = 4'h2, TAP_PAUSE_DR = 4'h3,
    TAP_SEL_IR    = 4'h4, TAP_UPDATE_DR = 4'h5, TAP_CAP_DR   = 4'h6, TAP_SEL_DR   = 4'h7,
    TAP_EXIT2_IR  = 4'h8, TAP_EXIT1_IR  = 4'h9, TAP_SHIFT_IR = 4'ha, TAP_PAUSE_IR = 4'hb,
    TAP_IDLE      = 4'hc, TAP_UPDATE_IR = 4'hd, TAP_CAP_IR   = 4'he, TAP_RESET    = 4'hf
  } flsl_tap_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } flsl_jtag_t;

  typedef struct packed {
    logic              req;
    logic [DATA_W-1:0] old_word;
    logic [DATA_W-1:0] new_word;
  } flsl_prog_t;

endpackage

// *** verif/flsl_flash_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Program flash array seen from the lockout block
// ------------------------------------------------------------
module flsl_flash_model #(
  parameter logic [15:0] SEC_INIT  = 16'h0002,  // Security word at power-up
  parameter logic [63:0] KEY_INIT  = 64'h0,     // Key words, first word in top bits
  parameter int          ERASE_CYC = 20         // Mass erase duration in clocks
) (
  input  wire logic        clk_in,          // 125 MHz clock
  input  wire logic [15:0] rd_addr_in,      // Boot read address
  output logic      [15:0] rd_data_out,     // Read data, one cycle late
  input  wire logic        prog_req_in,     // Program pulse for the security word
  input  wire logic [15:0] prog_data_in,    // Word to program
  input  wire logic        erase_req_in,    // Mass erase request
  output logic             erase_done_out   // Mass erase finished
);
  logic [15:0] mem_q [0:8];
  int          erase_cnt_q;

  // No reset input: contents survive every device reset
  initial begin
    mem_q[0] = SEC_INIT;
    for (int i = 1; i < 5; i++) mem_q[i] = 16'hffff;
    for (int i = 0; i < 4; i++) mem_q[5+i] = KEY_INIT[63-16*i -: 16];
    erase_done_out = 1'b0;
    erase_cnt_q = 0;
    rd_data_out = 16'hffff;
  end

  // Unmapped words read as erased
  always @(posedge clk_in) begin
    if (rd_addr_in >= 16'h1ff7 && rd_addr_in <= 16'h1fff) begin
      rd_data_out <= mem_q[int'(rd_addr_in - 16'h1ff7)];
    end else begin
      rd_data_out <= 16'hffff;
    end
  end

  // Programming only clears bits; only an erase brings ones back
  always @(posedge clk_in) begin
    if (prog_req_in) mem_q[0] <= mem_q[0] & prog_data_in;
    if (erase_req_in && !erase_done_out) begin
      if (erase_cnt_q == ERASE_CYC) begin
        for (int i = 0; i < 9; i++) mem_q[i] <= 16'hffff;
        erase_done_out <= 1'b1;
      end else begin
        erase_cnt_q <= erase_cnt_q + 1;
      end
    end else if (!erase_req_in) begin
      erase_done_out <= 1'b0;
      erase_cnt_q <= 0;
    end
  end
endmodule

// *** verif/flsl_lockout_bench.sv ***
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module flsl_lockout_bench;
  localparam logic [63:0] KEY_PK = 64'h3c5a_96e1_0f0f_c3a5;
  int                   fail_count;
  int                   tests_run;
  logic                 clk_in, rst_in, key_wr, flash_acc, erase_done, tdo, tdo_oe;
  logic                 prog_req, erase_req, prot_clear, secured, dbg_en, boot_done;
  logic [15:0]          key_data, rd_addr, rd_data, prog_data;
  logic [6:0]           clk_div;
  logic [31:0]          v;
  flsl_pkg::flsl_jtag_t jtag;
  flsl_pkg::flsl_prog_t prog;

  flsl_lockout uut (.clk_in(clk_in), .rst_in(rst_in), .jtag_in(jtag), .tdo_out(tdo),
    .tdo_oe_out(tdo_oe), .flash_rd_addr_out(rd_addr), .flash_rd_data_in(rd_data),
    .key_wr_in(key_wr), .key_data_in(key_data), .flash_acc_in(flash_acc), .prog_in(prog),
    .prog_req_out(prog_req), .prog_data_out(prog_data), .erase_done_in(erase_done),
    .erase_req_out(erase_req), .clk_div_out(clk_div), .prot_clear_out(prot_clear),
    .secured_out(secured), .dbg_en_out(dbg_en), .boot_done_out(boot_done));
  flsl_flash_model #(.SEC_INIT(16'h0002), .KEY_INIT(KEY_PK), .ERASE_CYC(20)) flash (
    .clk_in(clk_in), .rd_addr_in(rd_addr), .rd_data_out(rd_data), .prog_req_in(prog_req),
    .prog_data_in(prog_data), .erase_req_in(erase_req), .erase_done_out(erase_done));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic stop_test;
    $display("checks run %0d, failures %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wait_for(input string nm, ref logic sig, input int lim);
    for (int i = 0; i < lim && sig !== 1'b1; i++) begin
      @(posedge clk_in);
      #1;
    end
    if (sig !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED %s expected 1 seen %b", nm, sig);
      stop_test();
    end
  endtask

  // Slow TCK so the two-flop pin synchronisers never miss an edge
  task automatic tck_cyc(input logic tms, input logic tdi);
    @(posedge clk_in);
    jtag <= '{tck: 1'b0, tms: tms, tdi: tdi};
    repeat (8) @(posedge clk_in);
    jtag.tck <= 1'b1;
    repeat (8) @(posedge clk_in);
    jtag.tck <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask

  // TDO is taken before each rising TCK, where the last fall left it
  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      dout[i] = tdo;
      `CHK("tdo_oe", 1'b1, tdo_oe)
      tck_cyc(i == n - 1, din[i]);
    end
    tck_cyc(1'b1, 1'b0);
  endtask

  task automatic do_reset(input logic exp_sec);
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    `CHK("secured in reset", 1'b1, secured)
    `CHK("dbg_en in reset", 1'b0, dbg_en)
    @(posedge clk_in);
    rst_in <= 1'b0;
    wait_for("boot_done", boot_done, 20);
    repeat (2) @(posedge clk_in);
    #1;
    `CHK("secured", exp_sec, secured)
    `CHK("dbg_en", ~exp_sec, dbg_en)
    repeat (5) tck_cyc(1'b1, 1'b0);
    tck_cyc(1'b0, 1'b0);
  endtask

  // A plain access first, so no earlier partial key leaves the position advanced
  task automatic send_key(input logic [63:0] w, input bit brk);
    @(posedge clk_in);
    flash_acc <= 1'b1;
    @(posedge clk_in);
    flash_acc <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      key_wr <= 1'b1;
      key_data <= w[63-16*i -: 16];
      if (brk && i == 2) begin
        @(posedge clk_in);
        key_wr <= 1'b0;
        flash_acc <= 1'b1;
        @(posedge clk_in);
        flash_acc <= 1'b0;
      end
    end
    @(posedge clk_in);
    key_wr <= 1'b0;
    @(posedge clk_in);
    #1;
  endtask

  task automatic prog_word(input logic [15:0] old_w, input logic [15:0] new_w);
    @(posedge clk_in);
    prog <= '{req: 1'b1, old_word: old_w, new_word: new_w};
    @(posedge clk_in);
    prog.req <= 1'b0;
    #1;
    `CHK("prog_req", 1'b1, prog_req)
    `CHK("prog_data", old_w & new_w, prog_data)
    @(posedge clk_in);
    #1;
    `CHK("prog_req pulse", 1'b0, prog_req)
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_idcode;
    tck_cyc(1'b1, 1'b0);
    tck_cyc(1'b0, 1'b0);
    tck_cyc(1'b0, 1'b0);
    shift(32, 32'h0, v);
    `CHK("idcode", flsl_pkg::IDCODE_VAL, v)
    tck_cyc(1'b0, 1'b0);
  endtask

  task automatic t_keys;
    send_key(KEY_PK ^ 64'h1, 1'b0);
    `CHK("secured bad key", 1'b1, secured)
    send_key(KEY_PK, 1'b1);
    `CHK("secured broken key", 1'b1, secured)
    send_key(KEY_PK, 1'b0);
    `CHK("secured good key", 1'b0, secured)
    @(posedge clk_in);
    #1;
    `CHK("dbg_en good key", 1'b1, dbg_en)
    do_reset(1'b1);
  endtask

  task automatic t_lockout;
    tck_cyc(1'b1, 1'b0);
    tck_cyc(1'b1, 1'b0);
    tck_cyc(1'b0, 1'b0);
    tck_cyc(1'b0, 1'b0);
    shift(4, {28'h0, flsl_pkg::IR_LOCKOUT}, v);
    `CHK("ir capture", flsl_pkg::IR_CAPTURE, v[3:0])
    tck_cyc(1'b1, 1'b0);
    tck_cyc(1'b0, 1'b0);
    tck_cyc(1'b0, 1'b0);
    shift(7, 32'h2b, v);
    // The divider loads on the TCK rise that leaves Update-DR
    tck_cyc(1'b0, 1'b0);
    `CHK("clk_div", 7'h2b, clk_div)
    wait_for("erase_req", erase_req, 50);
    wait_for("prot_clear", prot_clear, 100);
    `CHK("erase_req after done", 1'b0, erase_req)
    `CHK("secured after erase", 1'b1, secured)
    @(posedge clk_in);
    #1;
    `CHK("prot_clear pulse", 1'b0, prot_clear)
    do_reset(1'b0);
  endtask

  task automatic t_program;
    prog_word(16'hffff, 16'h0002);
    do_reset(1'b1);
    prog_word(16'h0002, 16'hffff);
    prog_word(16'h0002, 16'h0000);
    do_reset(1'b0);
  endtask

  initial begin
    rst_in = 1'b1;
    jtag = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0};
    key_wr = 1'b0;
    key_data = 16'h0000;
    flash_acc = 1'b0;
    prog = '0;
    fail_count = 0;
    tests_run = 0;
    do_reset(1'b1);
    t_idcode();
    t_keys();
    t_lockout();
    t_program();
    stop_test();
  end
endmodule
